// ### verilog/ebedac_top.sv
// External bus error correction unit with AHB-Lite register slave
// Function
// - Protected writes get check bits; protected reads are checked and corrected.
// - Enable pin level, sampled per bus cycle, decides whether correction applies.
// - Check bits leave on the check port in protected writes, arrive in reads.
// - Control bits 6 and 5 choose which errors raise interrupts.
// - Control bit 4 reads set after an uncorrectable double error.
// - Control bits 3 to 0 count corrected single-bit errors.
// - Control/status register sits at index 15h of the register window.
// - Protected writes drive check bits before strobe rise and hold after.
`include "ebedac_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module ebedac_top (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [15:0] mem_wdata_i,
  output logic             mem_ack_o,
  output logic      [15:0] mem_rdata_o,
  output logic             mem_err_o,
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic      [15:0] ad_o,
  output logic             ad_oe_o,
  input  wire logic [15:0] ad_i,
  output logic      [4:0]  check_bit_port_o,
  output logic             check_bit_port_oe_o,
  input  wire logic [4:0]  check_bit_port_i,
  input  wire logic        ecc_cycle_enable_n_i,
  output logic             irq_o
);

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_q;
  wire logic rst_n;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end
  assign rst_n = rst_q;

  // Pin synchronisers; stage one feeds stage two only
  logic [21:0] pin_meta_q;
  logic [21:0] pin_sync_q;
  wire logic [15:0] ad_s;
  wire logic [4:0]  cb_s;
  wire logic        en_n_s;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 22'h3FFFFF;
      pin_sync_q <= 22'h3FFFFF;
    end else begin
      pin_meta_q <= {ecc_cycle_enable_n_i, check_bit_port_i, ad_i};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign ad_s   = pin_sync_q[15:0];
  assign cb_s   = pin_sync_q[20:16];
  assign en_n_s = pin_sync_q[21];

  // Bus cycle sequencer
  ebedac_pkg::ebedac_state_e state_q;
  ebedac_pkg::ebedac_state_e state_d;
  ebedac_pkg::ebedac_word_t  addr_q;
  ebedac_pkg::ebedac_word_t  wdat_q;
  ebedac_pkg::ebedac_word_t  rdat_q;
  ebedac_pkg::ebedac_word_t  rdata_q;
  ebedac_pkg::ebedac_chk_t   rchk_q;
  ebedac_pkg::ebedac_chk_t   wchk_q;
  logic       we_q;
  logic       en_q;
  logic [2:0] cnt_q;
  logic       sgl_q;
  logic       dbl_q;

  ebedac_codec_if cif ();
  ebedac_codec u_codec (.cif(cif.codec));

  assign cif.enc_data = wdat_q;
  assign cif.dec_data = rdat_q;
  assign cif.dec_chk  = rchk_q;

  wire logic accept;
  wire logic strb_end;
  wire logic prot_rd_done;
  wire logic sgl_evt;
  wire logic dbl_evt;

  // Accept needs only IDLE and a request; a request still high after ack starts a new cycle
  assign accept       = (state_q == ebedac_pkg::ST_IDLE) && mem_req_i;
  assign strb_end     = (state_q == ebedac_pkg::ST_STRB) && (cnt_q == 3'h1);
  assign prot_rd_done = (state_q == ebedac_pkg::ST_DONE) && !we_q && en_q;
  assign sgl_evt      = prot_rd_done && sgl_q;
  assign dbl_evt      = prot_rd_done && dbl_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ebedac_pkg::ST_IDLE: begin
        if (mem_req_i) begin
          state_d = ebedac_pkg::ST_ADDR;
        end
      end
      ebedac_pkg::ST_ADDR: begin
        state_d = ebedac_pkg::ST_STRB;
      end
      ebedac_pkg::ST_STRB: begin
        if (cnt_q == 3'h1) begin
          state_d = ebedac_pkg::ST_HOLD;
        end
      end
      ebedac_pkg::ST_HOLD: begin
        state_d = ebedac_pkg::ST_DONE;
      end
      default: begin
        state_d = ebedac_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ebedac_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == ebedac_pkg::ST_ADDR) ? `EBEDAC_STRB_CYC :
                 (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 16'h0000;
      wdat_q <= 16'h0000;
      we_q   <= 1'b0;
    end else if (accept) begin
      addr_q <= mem_addr_i;
      wdat_q <= mem_wdata_i;
      we_q   <= mem_we_i;
    end
  end

  // Enable is taken once, at the end of the address phase
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      wchk_q <= 5'h00;
    end else if (state_q == ebedac_pkg::ST_ADDR) begin
      en_q   <= !en_n_s;
      wchk_q <= cif.enc_chk;
    end
  end

  // Read data and check bits caught at strobe end, decoded in hold
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdat_q  <= 16'h0000;
      rchk_q  <= 5'h00;
      rdata_q <= 16'h0000;
      sgl_q   <= 1'b0;
      dbl_q   <= 1'b0;
    end else begin
      if (strb_end && !we_q) begin
        rdat_q <= ad_s;
        rchk_q <= cb_s;
      end
      if (state_q == ebedac_pkg::ST_HOLD) begin
        rdata_q <= en_q ? cif.dec_fixed : rdat_q;
        sgl_q   <= cif.dec_single;
        dbl_q   <= cif.dec_double;
      end
    end
  end

  wire logic wr_drive;
  assign wr_drive = we_q && ((state_q == ebedac_pkg::ST_STRB) ||
                             (state_q == ebedac_pkg::ST_HOLD));

  // Pin drive is decoded from state, no extra latency
  assign ale_o               = (state_q == ebedac_pkg::ST_ADDR);
  assign rd_n_o              = !((state_q == ebedac_pkg::ST_STRB) && !we_q);
  assign wr_n_o              = !((state_q == ebedac_pkg::ST_STRB) && we_q);
  assign ad_oe_o             = ale_o || wr_drive;
  assign ad_o                = ale_o ? addr_q : wdat_q;
  assign check_bit_port_oe_o = wr_drive && en_q;
  assign check_bit_port_o    = wchk_q;
  assign mem_ack_o           = (state_q == ebedac_pkg::ST_DONE);
  assign mem_rdata_o         = rdata_q;
  assign mem_err_o           = mem_ack_o && en_q && !we_q && dbl_q;

  // AHB-Lite slave, zero wait states
  wire logic       ahb_vld;
  wire logic [9:0] ahb_off;
  logic            wr_pend_q;
  logic [9:0]      wr_off_q;
  logic [31:0]     hrdata_q;

  assign ahb_vld = hsel_i && hready_i && htrans_i[1];
  assign ahb_off = haddr_i[9:0];

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= 10'h000;
    end else begin
      wr_pend_q <= ahb_vld && hwrite_i;
      wr_off_q  <= ahb_off;
    end
  end

  wire logic cs_wr;
  wire logic st_wr;
  wire logic mk_wr;
  assign cs_wr = wr_pend_q && (wr_off_q == {`EBEDAC_CS_IDX, 2'b00});
  assign st_wr = wr_pend_q && (wr_off_q == {`EBEDAC_STAT_IDX, 2'b00});
  assign mk_wr = wr_pend_q && (wr_off_q == {`EBEDAC_MASK_IDX, 2'b00});

  // Control/status: mode bits, double flag, saturating single count
  logic [1:0] mode_q;
  logic       dflag_q;
  logic [3:0] scnt_q;
  logic [3:0] scnt_d;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  wire logic [7:0] cs_val;
  wire logic [1:0] stat_set;

  assign cs_val = {1'b0, mode_q, dflag_q, scnt_q};

  always_comb begin
    scnt_d = cs_wr ? 4'h0 : scnt_q;
    if (sgl_evt) begin
      if (cs_wr) begin
        scnt_d = 4'h1;
      end else if (scnt_q != `EBEDAC_CNT_MAX) begin
        scnt_d = scnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= 2'h0;
      dflag_q <= 1'b0;
      scnt_q  <= 4'h0;
    end else begin
      if (cs_wr) begin
        mode_q <= hwdata_i[`EBEDAC_CS_MODE_DBL:`EBEDAC_CS_MODE_SGL];
      end
      dflag_q <= dbl_evt || (dflag_q && !cs_wr);
      scnt_q  <= scnt_d;
    end
  end

  // Mode bits decide which errors reach the interrupt status
  assign stat_set = {dbl_evt && mode_q[1], sgl_evt && mode_q[0]};

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= `EBEDAC_ST_RST;
      mask_q <= `EBEDAC_ST_RST;
    end else begin
      stat_q <= stat_set | (stat_q & ~(st_wr ? hwdata_i[1:0] : 2'h0));
      if (mk_wr) begin
        mask_q <= hwdata_i[1:0];
      end
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // Read data registered in the address phase; unmapped reads zero
  wire logic [31:0] rd_mux;
  assign rd_mux =
    (ahb_off == {`EBEDAC_CS_IDX, 2'b00})   ? {24'h000000, cs_val} :
    (ahb_off == {`EBEDAC_STAT_IDX, 2'b00}) ? {30'h00000000, stat_q} :
    (ahb_off == {`EBEDAC_MASK_IDX, 2'b00}) ? {30'h00000000, mask_q} :
    32'h00000000;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h00000000;
    end else if (ahb_vld && !hwrite_i) begin
      hrdata_q <= rd_mux;
    end
  end
  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Checks
  AST_ACK_TIME: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) accept |-> ##7 mem_ack_o)
    else $error("bus cycle ack not seven cycles after accept");
  AST_UNPROT_NO_CHK: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) ale_o && en_n_s |=> !check_bit_port_oe_o [*6])
    else $error("check port driven on unprotected cycle");
  AST_WR_CHK: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) !wr_n_o && en_q |-> check_bit_port_oe_o &&
    (check_bit_port_o == cif.enc_chk))
    else $error("check bits wrong during protected write");
  AST_WR_HOLD: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) $rose(wr_n_o) && en_q |-> check_bit_port_oe_o &&
    $stable(check_bit_port_o) ##1 !check_bit_port_oe_o)
    else $error("check bits not held one cycle after write strobe");
  AST_MODE_GATE: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) sgl_evt && !mode_q[0] && !stat_q[0] |=> !stat_q[0])
    else $error("single error raised status with mode off");
  AST_DBL_FLAG: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) dbl_evt |=> dflag_q && cs_val[`EBEDAC_CS_DBL])
    else $error("double flag not set after double error");
  AST_CNT_INC: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) sgl_evt && !cs_wr && (scnt_q != 4'hF) |=>
    scnt_q == $past(scnt_q) + 4'h1)
    else $error("single error count did not advance");
  AST_CS_READ: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) ahb_vld && !hwrite_i && (haddr_i[9:0] == 10'h054)
    |=> hrdata_o == {24'h000000, $past(cs_val)})
    else $error("control/status not read at its address");
  AST_CNT_SAT: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) (scnt_q == 4'hF) && !cs_wr |=> scnt_q == 4'hF)
    else $error("single error count wrapped");
  AST_CS_CLR: assert property (@(posedge core_clk_i)
    disable iff (!rst_n) cs_wr && !prot_rd_done |=>
    (scnt_q == 4'h0) && !dflag_q)
    else $error("register write did not clear count and flag");

  COV_PROT_WR: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(wr_n_o) && check_bit_port_oe_o);
  COV_SGL: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    sgl_evt);
  COV_DBL: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    dbl_evt);
  COV_IRQ: cover property (@(posedge core_clk_i) disable iff (!rst_n)
    $rose(irq_o));

endmodule : ebedac_top

`default_nettype wire

// ### verilog/ebedac_cfg.svh
// Constants for the external bus error correction unit
`ifndef EBEDAC_CFG_SVH
`define EBEDAC_CFG_SVH

// Register indices; byte address is four times the index
`define EBEDAC_CS_IDX      8'h15
`define EBEDAC_STAT_IDX    8'h16
`define EBEDAC_MASK_IDX    8'h17

// Control/status fields
`define EBEDAC_CS_MODE_DBL 6
`define EBEDAC_CS_MODE_SGL 5
`define EBEDAC_CS_DBL      4
`define EBEDAC_CS_CNT_MSB  3
`define EBEDAC_CS_CNT_LSB  0
`define EBEDAC_CS_RST      8'h00
`define EBEDAC_CNT_MAX     4'hF

// Interrupt status and mask fields
`define EBEDAC_ST_SGL      0
`define EBEDAC_ST_DBL      1
`define EBEDAC_ST_RST      2'h0

// Bus cycle timing in core clocks
`define EBEDAC_STRB_CYC    3'h4
`define EBEDAC_HOLD_CYC    1

`endif

// ### verilog/ebedac_pkg.sv
// Types for the external bus error correction unit
`default_nettype none

package ebedac_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_STRB = 3'b010,
    ST_HOLD = 3'b011,
    ST_DONE = 3'b100
  } ebedac_state_e;

  typedef logic [15:0] ebedac_word_t;
  typedef logic [4:0]  ebedac_chk_t;

endpackage : ebedac_pkg

`default_nettype wire

// ### verilog/ebedac_codec_if.sv
// Carrier between bus sequencer and check-bit codec
`timescale 1ns/100ps
`default_nettype none

interface ebedac_codec_if;
  ebedac_pkg::ebedac_word_t enc_data;
  ebedac_pkg::ebedac_chk_t  enc_chk;
  ebedac_pkg::ebedac_word_t dec_data;
  ebedac_pkg::ebedac_chk_t  dec_chk;
  ebedac_pkg::ebedac_word_t dec_fixed;
  logic                     dec_single;
  logic                     dec_double;

  modport user (
    output enc_data,
    output dec_data,
    output dec_chk,
    input  enc_chk,
    input  dec_fixed,
    input  dec_single,
    input  dec_double
  );

  modport codec (
    input  enc_data,
    input  dec_data,
    input  dec_chk,
    output enc_chk,
    output dec_fixed,
    output dec_single,
    output dec_double
  );
endinterface : ebedac_codec_if

`default_nettype wire

// ### verilog/ebedac_codec.sv
// Check-bit generator and single-error corrector, 16 data bits, 5 check bits
`timescale 1ns/100ps
`default_nettype none

module ebedac_codec (
  ebedac_codec_if.codec cif
);

  // Distinct columns of weight two or three, so none aliases a check bit
  function automatic logic [4:0] col(input int idx);
    case (idx)
      0:       col = 5'h03;
      1:       col = 5'h05;
      2:       col = 5'h06;
      3:       col = 5'h09;
      4:       col = 5'h0A;
      5:       col = 5'h0C;
      6:       col = 5'h11;
      7:       col = 5'h12;
      8:       col = 5'h14;
      9:       col = 5'h18;
      10:      col = 5'h07;
      11:      col = 5'h0B;
      12:      col = 5'h0D;
      13:      col = 5'h0E;
      14:      col = 5'h13;
      default: col = 5'h15;
    endcase
  endfunction : col

  function automatic logic [4:0] gen_chk(input logic [15:0] d);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) begin
        c = c ^ col(i);
      end
    end
    gen_chk = c;
  endfunction : gen_chk

  wire logic [4:0]  syn;
  wire logic [15:0] hit;
  wire logic        chk_hit;

  assign cif.enc_chk = gen_chk(cif.enc_data);
  assign syn         = gen_chk(cif.dec_data) ^ cif.dec_chk;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_fix
      assign hit[g]           = (syn == col(g));
      assign cif.dec_fixed[g] = cif.dec_data[g] ^ hit[g];
    end
  endgenerate

  // A flipped check bit leaves a weight-one syndrome; data is already good
  assign chk_hit        = (syn != 5'h00) && ((syn & (syn - 5'h01)) == 5'h00);
  assign cif.dec_single = (|hit) | chk_hit;
  // Five check bits cannot catch every double; unmatched syndromes flag it
  assign cif.dec_double = (syn != 5'h00) && !cif.dec_single;

endmodule : ebedac_codec

`default_nettype wire

// ### tb/ebedac_mem_model.sv
// External memory and region decode model facing the error correction unit
`timescale 1ns/100ps
`default_nettype none

module ebedac_mem_model (
  input  wire logic        clk_i,
  input  wire logic        protect_i,
  input  wire logic [15:0] flip_data_i,
  input  wire logic [4:0]  flip_chk_i,
  input  wire logic        ale_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] ad_i,
  input  wire logic        ad_oe_i,
  input  wire logic [4:0]  cb_i,
  input  wire logic        cb_oe_i,
  output logic      [15:0] ad_o,
  output logic      [4:0]  cb_o,
  output logic             enable_n_o,
  output logic             viol_o,
  output logic      [4:0]  stored_chk_o
);
  logic [15:0] mem_q [256];
  logic [4:0]  chk_q [256];
  logic [7:0]  addr_q;
  logic        wr_low_q;
  logic [20:0] junk_q = 21'h0A5A5A;
  logic        legacy_external_access_select;

  // Region decode level, steady well around each cycle
  assign enable_n_o   = ~protect_i;
  // Grounded only while the region runs without check bits
  assign legacy_external_access_select = protect_i;
  // Released bus shows a changing pattern so stale data cannot pass
  assign ad_o = !rd_n_i ? mem_q[addr_q] ^ flip_data_i : junk_q[15:0];
  assign cb_o = !rd_n_i ? chk_q[addr_q] ^ flip_chk_i : junk_q[20:16];
  assign stored_chk_o = chk_q[addr_q];

  initial viol_o = 1'b0;

  always @(posedge clk_i) begin
    junk_q   <= ~junk_q;
    wr_low_q <= !wr_n_i;
    if (ale_i) begin
      addr_q <= ad_i[7:0];
    end
    if (!wr_n_i) begin
      mem_q[addr_q] <= ad_i;
      if (cb_oe_i) begin
        chk_q[addr_q] <= cb_i;
      end
    end
    if (wr_low_q && !wr_n_i && ad_i !== mem_q[addr_q]) begin
      viol_o <= 1'b1;
    end
    // Data and check bits must outlast the write strobe
    if (wr_low_q && wr_n_i && (!ad_oe_i || cb_oe_i !== protect_i)) begin
      viol_o <= 1'b1;
    end
    if (!wr_n_i && cb_oe_i !== protect_i) begin
      viol_o <= 1'b1;
    end
    if (protect_i && !legacy_external_access_select) begin
      viol_o <= 1'b1;
    end
  end
endmodule : ebedac_mem_model

`default_nettype wire

// ### tb/test_ebedac_top.sv
// Self-checking bench for the external bus error correction unit
`include "ebedac_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module test_ebedac_top;
  localparam logic [4:0] COLS [16] = '{5'h03, 5'h05, 5'h06, 5'h09, 5'h0A,
    5'h0C, 5'h11, 5'h12, 5'h14, 5'h18, 5'h07, 5'h0B, 5'h0D, 5'h0E, 5'h13,
    5'h15};
  localparam logic [31:0] A_CS = {22'h0, `EBEDAC_CS_IDX, 2'b00};
  localparam logic [31:0] A_ST = {22'h0, `EBEDAC_STAT_IDX, 2'b00};
  localparam logic [31:0] A_MK = {22'h0, `EBEDAC_MASK_IDX, 2'b00};
  localparam logic [15:0] VALS [4] = '{16'h0000, 16'hFFFF, 16'h1234,
    16'h8001};

  logic        core_clk_i, rst_n_i, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        mem_req, mem_we, mem_ack, mem_err, ale, rd_n, wr_n, ad_oe;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, r16;
  logic        cb_oe, en_n, irq, viol, protect, e1;
  logic [15:0] ad_dut, ad_mdl, ad_w, flip_d;
  logic [4:0]  cb_dut, cb_mdl, cb_w, flip_c, st_chk;
  int          n_errors, num_checks;

  // Wire level from whichever party drives
  assign ad_w = ad_oe ? ad_dut : ad_mdl;
  assign cb_w = cb_oe ? cb_dut : cb_mdl;

  ebedac_top i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .mem_req_i(mem_req), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata),
    .mem_err_o(mem_err), .ale_o(ale), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .ad_o(ad_dut), .ad_oe_o(ad_oe), .ad_i(ad_w),
    .check_bit_port_o(cb_dut), .check_bit_port_oe_o(cb_oe),
    .check_bit_port_i(cb_w), .ecc_cycle_enable_n_i(en_n), .irq_o(irq));

  ebedac_mem_model i_mem (
    .clk_i(core_clk_i), .protect_i(protect), .flip_data_i(flip_d),
    .flip_chk_i(flip_c), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .ad_i(ad_w), .ad_oe_i(ad_oe), .cb_i(cb_w), .cb_oe_i(cb_oe),
    .ad_o(ad_mdl), .cb_o(cb_mdl), .enable_n_o(en_n), .viol_o(viol),
    .stored_chk_o(st_chk));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [4:0] cbits(input logic [15:0] d);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) if (d[i]) c ^= COLS[i];
    return c;
  endfunction : cbits

  task automatic wait_ready;
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (hreadyout === 1'b1) break;
    end
    if (n == 40) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_ready

  task automatic reg_acc(input logic w, input logic [31:0] a,
                         input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
  endtask : reg_acc

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    reg_acc(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    reg_acc(1'b0, a, 32'h0, r);
    chk(r, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask : rdc

  task automatic mem_op(input logic w, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] r,
                        output logic e);
    int n;
    @(posedge core_clk_i);
    mem_req   <= 1'b1;
    mem_we    <= w;
    mem_addr  <= a;
    mem_wdata <= d;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk_i);
      if (mem_ack === 1'b1) break;
    end
    if (n == 40) begin
      n_errors++;
      complete_run();
    end
    r = mem_rdata;
    e = mem_err;
    mem_req <= 1'b0;
  endtask : mem_op

  task automatic mrd(input logic [15:0] a, input logic [15:0] d,
                     input logic e);
    logic [15:0] r;
    logic        er;
    mem_op(1'b0, a, 16'h0000, r, er);
    chk({16'h0000, r}, {16'h0000, d});
    chk({31'h0, er}, {31'h0, e});
  endtask : mrd

  // Enable level settles long before the next request is taken
  task automatic cfg(input logic p, input logic [15:0] fd,
                     input logic [4:0] fc);
    @(posedge core_clk_i);
    protect <= p;
    flip_d  <= fd;
    flip_c  <= fc;
    repeat (3) @(posedge core_clk_i);
  endtask : cfg

  initial begin
    rst_n_i = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0;
    hwrite = 1'b0; hwdata = 32'h0; mem_req = 1'b0; mem_we = 1'b0;
    mem_addr = 16'h0; mem_wdata = 16'h0; protect = 1'b0;
    flip_d = 16'h0; flip_c = 5'h0; n_errors = 0; num_checks = 0;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rdc(A_CS, 32'h0);
    rdc(A_ST, 32'h0);
    rdc(A_MK, 32'h0);
    wr(32'h60, 32'hFF);
    rdc(32'h60, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset and map done");
    cfg(1'b0, 16'h0001, 5'h00);
    mem_op(1'b1, 16'h0010, 16'hA5A5, r16, e1);
    mrd(16'h0010, 16'hA5A4, 1'b0);
    rdc(A_CS, 32'h0);
    $display("test unprotected done");
    cfg(1'b1, 16'h0000, 5'h00);
    for (int i = 0; i < 4; i++) begin
      mem_op(1'b1, 16'h0020 + 16'(i), VALS[i], r16, e1);
      chk({27'h0, st_chk}, {27'h0, cbits(VALS[i])});
      mrd(16'h0020 + 16'(i), VALS[i], 1'b0);
    end
    chk({31'h0, viol}, 32'h0);
    $display("test protected done");
    wr(A_CS, 32'h20);
    wr(A_MK, 32'h3);
    cfg(1'b1, 16'h0008, 5'h00);
    mrd(16'h0022, 16'h1234, 1'b0);
    rdc(A_CS, 32'h21);
    rdc(A_ST, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(A_ST, 32'h1);
    rdc(A_ST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(A_CS, 32'h0);
    cfg(1'b1, 16'h0000, 5'h04);
    mrd(16'h0022, 16'h1234, 1'b0);
    rdc(A_CS, 32'h1);
    rdc(A_ST, 32'h0);
    $display("test single error done");
    wr(A_CS, 32'h40);
    cfg(1'b1, 16'h8001, 5'h00);
    mem_op(1'b0, 16'h0023, 16'h0000, r16, e1);
    chk({31'h0, e1}, 32'h1);
    rdc(A_CS, 32'h50);
    rdc(A_ST, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(A_ST, 32'h2);
    wr(A_CS, 32'h0);
    rdc(A_CS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test double error done");
    cfg(1'b1, 16'h0100, 5'h00);
    repeat (17) mrd(16'h0021, 16'hFFFF, 1'b0);
    rdc(A_CS, 32'h0F);
    wr(A_CS, 32'h0);
    rdc(A_CS, 32'h0);
    chk({31'h0, viol}, 32'h0);
    $display("test saturation done");
    complete_run();
  end
endmodule : test_ebedac_top

`default_nettype wire
